// [logic/swc_sleep_ctrl.sv]
// The AHB-Lite slave port and the register offsets were chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none
// How it works
// - power-down is entered only on the sleep opcode from the core
// - on entry clear watchdog if enabled, clear powerdown flag, set timeout flag, stop oscillator
// - pin drive states are frozen for the whole power-down
// - wake on master clear, enabled watchdog time-out, or enabled interrupt
// - master clear gives full reset; other wakes resume execution
// - powerdown flag set at power-up, cleared on each sleep entry
// - timeout flag cleared when a watchdog time-out caused the wake
// - only the nine listed peripheral sources may wake the device
// - clocked peripherals raise no wake interrupts during power-down
// - next instruction address is prefetched while the sleep opcode executes
// - wake needs the source enable bit, regardless of global enable
// - global enable off continues in-line, on branches to vector 0004h
// - sleep with an enabled flag already pending acts as a no-op
// - interrupt during or after sleep lets sleep complete, then wakes at once
// - crystal modes wait 1024 oscillator periods before resuming, RC mode none
module swc_sleep_ctrl
    import swc_pkg::*;
#(
    parameter int PC_W = 13
) (
    input  wire logic                       clk,
    input  wire logic                       reset,
    input  wire logic                       powerOnReset,
    input  wire logic                       masterClearPin,
    input  wire logic                       sleepOp,
    input  wire logic [PC_W-1:0]            currentPc,
    input  wire logic                       globalIrqEnable,
    input  wire logic                       watchdogEnable,
    input  wire logic                       watchdogTimeout,
    input  wire logic                       extIntFlag,
    input  wire logic                       extIntEnable,
    input  wire logic                       portBChangeFlag,
    input  wire logic                       portBChangeEnable,
    input  wire logic [PERIPH_N-1:0]        periphFlag,
    input  wire logic [PERIPH_N-1:0]        periphEnable,
    input  wire logic                       oscTick,
    input  wire logic [7:0]                 pinOutIn,
    input  wire logic [7:0]                 pinOeIn,
    input  wire logic                       hsel,
    input  wire logic [31:0]                haddr,
    input  wire logic [1:0]                 htrans,
    input  wire logic                       hwrite,
    input  wire logic [2:0]                 hsize,
    input  wire logic [31:0]                hwdata,
    input  wire logic                       hready,
    output logic [31:0]                     hrdata,
    output logic                            hreadyout,
    output logic                            hresp,
    output logic                            irq,
    output logic                            powerdownFlag,
    output logic                            timeoutFlag,
    output logic                            oscDriverOn,
    output logic                            watchdogClear,
    output logic                            coreStall,
    output logic                            deviceReset,
    output logic                            vectorJump,
    output logic [PC_W-1:0]                 prefetchPc,
    output logic [7:0]                      pinOut,
    output logic [7:0]                      pinOe
);
    import swc_pkg::*;

    function automatic logic anyWake(input logic [SRC_N-1:0] f,
                                     input logic [SRC_N-1:0] e);
        anyWake = |(f & e);
    endfunction : anyWake

    // pin-side inputs pass two flops
    logic [1:0] mclrSync;
    logic [1:0] extSync;
    logic [1:0] rbSync;
    logic [PERIPH_N-1:0] perSync1;
    logic [PERIPH_N-1:0] perSync2;
    always_ff @(posedge clk) begin
        if (reset) begin
            mclrSync <= 2'b11;
            extSync  <= 2'b00;
            rbSync   <= 2'b00;
            perSync1 <= '0;
            perSync2 <= '0;
        end else begin
            mclrSync <= {mclrSync[0], masterClearPin};
            extSync  <= {extSync[0], extIntFlag};
            rbSync   <= {rbSync[0], portBChangeFlag};
            perSync1 <= periphFlag;
            perSync2 <= perSync1;
        end
    end

    swc_state_type state;
    logic [10:0]   ostCount;
    logic [EV_N-1:0] irqStatus;
    logic [EV_N-1:0] irqMask;
    logic [31:0]   ctrl;
    logic          crystalMode;
    logic          mclrLow;
    logic          irqWake;
    logic          wdtWake;
    logic          inSleep;
    logic          wakeGlobal;

    assign crystalMode = ctrl[0];
    assign mclrLow     = ~mclrSync[1];
    // listed sources
    // only the wake-capable peripheral set is wired in; clocked ones are not inputs
    // enable gates wake
    assign irqWake = anyWake({extSync[1], rbSync[1], perSync2},
                             {extIntEnable, portBChangeEnable, periphEnable});
    assign wdtWake = watchdogEnable & watchdogTimeout;
    assign inSleep = (state == SWC_SLEEP);

    always_ff @(posedge clk) begin
        if (reset) begin
            state    <= SWC_RUN;
            ostCount <= '0;
        end else begin
            case (state)
                SWC_RUN: begin
                    if (sleepOp && !irqWake && !mclrLow) begin
                        state <= SWC_SLEEP;
                    end
                end
                SWC_SLEEP: begin
                    if (mclrLow) begin
                        state <= SWC_RUN;
                    end else if (irqWake || wdtWake) begin
                        ostCount <= crystalMode ? OST_COUNT : 11'h0_000;
                        state    <= crystalMode ? SWC_OST : SWC_RESUME;
                    end
                end
                SWC_OST: begin
                    if (mclrLow) begin
                        state <= SWC_RUN;
                    end else if (ostCount == 11'h0_000) begin
                        state <= SWC_RESUME;
                    end else if (oscTick) begin
                        ostCount <= ostCount - 11'h0_001;
                    end
                end
                SWC_RESUME: begin
                    state <= SWC_RUN;
                end
                default: begin
                    state <= SWC_RUN;
                end
            endcase
        end
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            powerdownFlag <= 1'b1;
            timeoutFlag   <= 1'b1;
        end else if (powerOnReset) begin
            powerdownFlag <= 1'b1;
            timeoutFlag   <= 1'b1;
        end else if (state == SWC_RUN && sleepOp && !irqWake && !mclrLow) begin
            powerdownFlag <= 1'b0;
            timeoutFlag   <= 1'b1;
        end else if (inSleep && !mclrLow && !irqWake && wdtWake) begin
            timeoutFlag <= 1'b0;
        end
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            watchdogClear <= 1'b0;
            oscDriverOn   <= 1'b1;
        end else begin
            watchdogClear <= state == SWC_RUN && sleepOp && !irqWake && !mclrLow
                             && watchdogEnable;
            if (state == SWC_RUN && sleepOp && !irqWake && !mclrLow) begin
                oscDriverOn <= 1'b0;
            end else if (state == SWC_SLEEP && !(irqWake || wdtWake || mclrLow)) begin
                oscDriverOn <= 1'b0;
            end else begin
                oscDriverOn <= 1'b1;
            end
        end
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            coreStall   <= 1'b0;
            deviceReset <= 1'b0;
            vectorJump  <= 1'b0;
            prefetchPc  <= '0;
            wakeGlobal  <= 1'b0;
        end else begin
            deviceReset <= (state != SWC_RUN) && mclrLow;
            coreStall   <= (state == SWC_RUN && sleepOp && !irqWake && !mclrLow)
                           || (state == SWC_SLEEP && !mclrLow)
                           || (state == SWC_OST && !mclrLow && ostCount != 11'h0_000);
            if (state == SWC_RUN && sleepOp) begin
                prefetchPc <= currentPc + PC_W'(1);
            end
            if (state == SWC_SLEEP) begin
                wakeGlobal <= irqWake & globalIrqEnable;
            end
            vectorJump <= (state == SWC_RESUME) && wakeGlobal;
        end
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            pinOut <= 8'h00;
            pinOe  <= 8'h00;
        end else if (state == SWC_RUN && !(sleepOp && !irqWake && !mclrLow)) begin
            pinOut <= pinOutIn;
            pinOe  <= pinOeIn;
        end
    end

    // bus slave
    logic       dWrite;
    logic [7:0] dAddr;
    logic       readStatus;
    always_ff @(posedge clk) begin
        if (reset) begin
            dWrite <= 1'b0;
            dAddr  <= 8'h00;
        end else if (hready) begin
            dWrite <= hsel && htrans[1] && hwrite;
            dAddr  <= haddr[7:0];
        end else begin
            dWrite <= 1'b0;
        end
    end
    // clear on the edge that copies irqStatus into hrdata, so no event slips between
    assign readStatus = hready && hsel && htrans[1] && !hwrite && haddr[7:0] == ADDR_IRQ_ST;

    logic [EV_N-1:0] events;
    always_comb begin
        events = '0;
        events[EV_SLEEP] = state == SWC_RUN && sleepOp && !irqWake && !mclrLow;
        events[EV_WAKE]  = inSleep && (irqWake || wdtWake) && !mclrLow;
        events[EV_WDT]   = inSleep && wdtWake && !irqWake && !mclrLow;
        events[EV_NOP]   = state == SWC_RUN && sleepOp && irqWake;
    end

    // set wins over read-clear
    always_ff @(posedge clk) begin
        if (reset) begin
            irqStatus <= '0;
            irqMask   <= '0;
            ctrl      <= RESET_CTRL;
            irq       <= 1'b0;
        end else begin
            irqStatus <= (readStatus ? '0 : irqStatus) | events;
            if (dWrite && dAddr == ADDR_IRQ_MSK) begin
                irqMask <= hwdata[EV_N-1:0];
            end
            if (dWrite && dAddr == ADDR_CTRL) begin
                ctrl <= {31'h0000_0000, hwdata[0]};
            end
            irq <= |(((readStatus ? '0 : irqStatus) | events) & irqMask);
        end
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            hrdata <= 32'h0000_0000;
        end else if (hready && hsel && htrans[1] && !hwrite) begin
            case (haddr[7:0])
                ADDR_STATUS: begin
                    hrdata <= {27'h000_0000, timeoutFlag, powerdownFlag, 1'b0, 2'b00}
                              | {28'h000_0000, state};
                end
                ADDR_IRQ_ST:  hrdata <= {28'h000_0000, irqStatus};
                ADDR_IRQ_MSK: hrdata <= {28'h000_0000, irqMask};
                ADDR_CTRL:    hrdata <= ctrl;
                default:      hrdata <= 32'h0000_0000;
            endcase
        end
    end
    always_ff @(posedge clk) begin
        if (reset) begin
            hreadyout <= 1'b1;
            hresp     <= 1'b0;
        end else begin
            hreadyout <= 1'b1;
            hresp     <= 1'b0;
        end
    end

    nop_keeps_pd_a: assert property (@(posedge clk) disable iff (reset)
        (state == SWC_RUN && sleepOp && irqWake && !powerOnReset) |=> powerdownFlag == $past(powerdownFlag))
        else $error("sleep no-op changed powerdown flag");
    entry_clears_pd_a: assert property (@(posedge clk) disable iff (reset)
        (state == SWC_RUN && sleepOp && !irqWake && !mclrLow && !powerOnReset)
        |=> !powerdownFlag && timeoutFlag && !oscDriverOn && state == SWC_SLEEP)
        else $error("sleep entry status wrong");
    wdt_wake_to_a: assert property (@(posedge clk) disable iff (reset)
        (inSleep && wdtWake && !irqWake && !mclrLow && !powerOnReset) |=> !timeoutFlag)
        else $error("watchdog wake left timeout flag set");
    sleep_by_op_a: assert property (@(posedge clk) disable iff (reset)
        (state == SWC_RUN && !sleepOp) |=> state != SWC_SLEEP)
        else $error("sleep without opcode");
    master_clear_pin_reset_a: assert property (@(posedge clk) disable iff (reset)
        (inSleep && mclrLow) |=> deviceReset && state == SWC_RUN)
        else $error("master clear did not reset");
    sequence wakeGie_s;
        inSleep && irqWake && globalIrqEnable && !mclrLow && !crystalMode;
    endsequence
    vector_jump_a: assert property (@(posedge clk) disable iff (reset)
        wakeGie_s |=> ##1 vectorJump)
        else $error("no vector after enabled wake");
    rc_no_delay_a: assert property (@(posedge clk) disable iff (reset)
        (inSleep && (irqWake || wdtWake) && !mclrLow && !crystalMode) |=> state == SWC_RESUME)
        else $error("rc wake delayed");
    pins_frozen_a: assert property (@(posedge clk) disable iff (reset)
        (inSleep && $past(inSleep)) |-> $stable(pinOut) && $stable(pinOe))
        else $error("pins moved in sleep");
    osc_on_resume_a: assert property (@(posedge clk) disable iff (reset)
        (state == SWC_RESUME) |-> oscDriverOn)
        else $error("oscillator off at resume");
    prefetch_a: assert property (@(posedge clk) disable iff (reset)
        (state == SWC_RUN && sleepOp) |=> prefetchPc == $past(currentPc) + PC_W'(1))
        else $error("prefetch address wrong");
    sequence quietWake_s;
        inSleep && (irqWake || wdtWake) && !mclrLow;
    endsequence
    wake_no_reset_a: assert property (@(posedge clk) disable iff (reset)
        quietWake_s |=> !deviceReset)
        else $error("wake without master clear reset the core");
    ost_load_a: assert property (@(posedge clk) disable iff (reset)
        (inSleep && (irqWake || wdtWake) && !mclrLow && crystalMode)
        |=> state == SWC_OST && ostCount == OST_COUNT)
        else $error("start-up count not loaded");
    wdt_no_vector_a: assert property (@(posedge clk) disable iff (reset)
        (inSleep && wdtWake && !irqWake && !mclrLow) |=> ##1 !vectorJump)
        else $error("vector after watchdog wake");
    nop_no_sleep_a: assert property (@(posedge clk) disable iff (reset)
        (state == SWC_RUN && sleepOp && irqWake && !powerOnReset)
        |=> state == SWC_RUN && !watchdogClear && oscDriverOn
            && timeoutFlag == $past(timeoutFlag))
        else $error("sleep no-op entered sleep");
    osc_off_sleep_a: assert property (@(posedge clk) disable iff (reset)
        (inSleep && $past(inSleep)) |-> !oscDriverOn)
        else $error("oscillator on during sleep");
    no_wake_idle_a: assert property (@(posedge clk) disable iff (reset)
        (inSleep && !irqWake && !wdtWake && !mclrLow) |=> inSleep)
        else $error("woke without enabled source");
endmodule : swc_sleep_ctrl
`default_nettype wire

// [shared/swc_pkg.sv]
package swc_pkg;
    // status bit positions
    localparam int STATUS_PD_BIT = 3;
    localparam int STATUS_TO_BIT = 4;
    localparam int STATUS_W      = 8;
    // interrupt vector
    localparam logic [12:0] IRQ_VECTOR = 13'h0004;
    // wake-capable peripheral sources
    localparam int PERIPH_N = 9;
    localparam int SRC_N    = 11;
    // oscillator start-up delay in oscillator periods
    localparam int OST_PERIODS = 1024;
    localparam logic [10:0] OST_COUNT = 11'(OST_PERIODS);
    // register map over AHB-Lite
    localparam logic [7:0] ADDR_STATUS  = 8'h00;
    localparam logic [7:0] ADDR_IRQ_ST  = 8'h04;
    localparam logic [7:0] ADDR_IRQ_MSK = 8'h08;
    localparam logic [7:0] ADDR_CTRL    = 8'h0C;
    localparam logic [31:0] RESET_CTRL  = 32'h0000_0000;
    // interrupt status bits
    localparam int EV_SLEEP = 0;
    localparam int EV_WAKE  = 1;
    localparam int EV_WDT   = 2;
    localparam int EV_NOP   = 3;
    localparam int EV_N     = 4;
    typedef enum logic [3:0] {
        SWC_RUN   = 4'b0001,
        SWC_SLEEP = 4'b0010,
        SWC_OST   = 4'b0100,
        SWC_RESUME= 4'b1000
    } swc_state_type;
endpackage : swc_pkg

// [tb/swc_periph_model.sv]
`timescale 1ns/1ps
`default_nettype none
module swc_periph_model (
    input  wire logic        clk,
    input  wire logic        reset,
    input  wire logic        oscDriverOn,
    input  wire logic [10:0] fire,
    input  wire logic        clear,
    output logic [10:0]      flags,
    output logic             oscTick
);
    logic tickPhase;
    always_ff @(posedge clk) begin
        if (reset || clear) begin
            flags <= '0;
        end else begin
            flags <= flags | fire;
        end
    end
    // a stopped crystal gives no ticks, so the start-up count begins at wake
    always_ff @(posedge clk) begin
        tickPhase <= !reset && !tickPhase;
        oscTick   <= !reset && oscDriverOn && tickPhase;
    end
endmodule : swc_periph_model
`default_nettype wire

// [tb/sleep_wakeup_controller_test.sv]
`timescale 1ns/1ps
`default_nettype none
module sleep_wakeup_controller_test;
    import swc_pkg::*;
    logic        clk, reset, powerOnReset, masterClearPin, sleepOp, globalIrqEnable;
    logic        watchdogEnable, watchdogTimeout, oscTick, hsel, hwrite, clearFlags;
    logic        hreadyout, hresp, irq, powerdownFlag, timeoutFlag, oscDriverOn;
    logic        watchdogClear, coreStall, deviceReset, vectorJump;
    logic [12:0] currentPc, prefetchPc;
    logic [10:0] enables, fire, flags;
    logic [7:0]  pinOutIn, pinOeIn, pinOut, pinOe;
    logic [31:0] haddr, hwdata, hrdata, rd;
    logic [1:0]  htrans;
    logic [2:0]  hsize;
    int          mismatches, total_checks, clrCnt, vecCnt, tickCnt, c0, v0;

    swc_sleep_ctrl dut (
        .clk(clk), .reset(reset), .powerOnReset(powerOnReset),
        .masterClearPin(masterClearPin), .sleepOp(sleepOp), .currentPc(currentPc),
        .globalIrqEnable(globalIrqEnable), .watchdogEnable(watchdogEnable),
        .watchdogTimeout(watchdogTimeout), .extIntFlag(flags[0]), .extIntEnable(enables[0]),
        .portBChangeFlag(flags[1]), .portBChangeEnable(enables[1]),
        .periphFlag(flags[10:2]), .periphEnable(enables[10:2]), .oscTick(oscTick),
        .pinOutIn(pinOutIn), .pinOeIn(pinOeIn), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
        .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
        .irq(irq), .powerdownFlag(powerdownFlag), .timeoutFlag(timeoutFlag),
        .oscDriverOn(oscDriverOn), .watchdogClear(watchdogClear), .coreStall(coreStall),
        .deviceReset(deviceReset), .vectorJump(vectorJump), .prefetchPc(prefetchPc),
        .pinOut(pinOut), .pinOe(pinOe)
    );

    swc_periph_model model (
        .clk(clk), .reset(reset), .oscDriverOn(oscDriverOn), .fire(fire),
        .clear(clearFlags), .flags(flags), .oscTick(oscTick)
    );

    initial begin
        clk = 1'b0;
        forever #5 clk = !clk;
    end

    always @(posedge clk) begin
        if (watchdogClear === 1'b1) clrCnt <= clrCnt + 1;
        if (vectorJump === 1'b1) vecCnt <= vecCnt + 1;
        if (oscTick === 1'b1 && coreStall === 1'b1) tickCnt <= tickCnt + 1;
    end

    task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
        total_checks++;
        if (seen !== exp) begin
            mismatches++;
            $display("ERROR %s expected %h seen %h", name, exp, seen);
        end
    endtask : check

    task automatic results();
        $display("checks %0d mismatches %0d", total_checks, mismatches);
        if (mismatches == 0 && total_checks > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask : results

    task automatic waitSig(ref logic s, input logic v, input int lim);
        int n;
        n = 0;
        while (s !== v) begin
            n++;
            if (n > lim) begin
                mismatches++;
                results();
            end
            @(posedge clk);
            #1;
        end
    endtask : waitSig

    // the single slave answers at once, but the master still waits for ready
    task automatic ahb(input logic wr, input logic [7:0] a, input logic [31:0] wd);
        int n;
        n = 0;
        @(posedge clk);
        {hsel, htrans, hwrite, hsize} <= {1'b1, 2'b10, wr, 3'b010};
        haddr <= 32'(a);
        do begin
            @(posedge clk);
            n++;
        end while (hreadyout !== 1'b1 && n < 20);
        {hsel, htrans} <= 3'b000;
        hwdata <= wd;
        do begin
            @(posedge clk);
            n++;
        end while (hreadyout !== 1'b1 && n < 40);
        rd = hrdata;
        if (hreadyout !== 1'b1) begin
            mismatches++;
            results();
        end
    endtask : ahb

    task automatic doSleep(input logic [10:0] f);
        logic [15:0] p;
        logic [12:0] pc;
        p = 16'($urandom);
        pc = 13'($urandom);
        @(posedge clk);
        {pinOeIn, pinOutIn} <= p;
        c0 = clrCnt;
        watchdogTimeout <= 1'b0;
        @(posedge clk);
        sleepOp <= 1'b1;
        currentPc <= pc;
        fire <= f;
        @(posedge clk);
        {sleepOp, fire} <= '0;
        {pinOeIn, pinOutIn} <= ~p;
        repeat (2) @(posedge clk);
        #1;
        if (f == 11'h000 && coreStall === 1'b1) begin
            check("pinOut", pinOut, p[7:0]);
            check("pinOe", pinOe, p[15:8]);
            check("prefetchPc", prefetchPc, 13'(pc + 13'h0001));
            check("oscDriverOn", oscDriverOn, 1'b0);
            check("timeoutFlag", timeoutFlag, 1'b1);
        end
    endtask : doSleep

    initial begin
        {powerOnReset, sleepOp, globalIrqEnable, watchdogTimeout, hsel, hwrite} = '0;
        {currentPc, enables, fire, pinOutIn, pinOeIn, haddr, hwdata, htrans, hsize} = '0;
        {reset, masterClearPin, watchdogEnable, clearFlags} = 4'b1110;
        void'($urandom(50249));
        repeat (20) @(posedge clk);
        reset <= 1'b0;
        repeat (30) @(posedge clk);
        #1;
        check("coreStall", coreStall, 1'b0);
        check("powerdownFlag", powerdownFlag, 1'b1);
        for (int i = 0; i < 11; i++) begin
            @(posedge clk);
            globalIrqEnable <= 1'($urandom);
            clearFlags <= 1'b0;
            v0 = vecCnt;
            doSleep(11'h000);
            check("powerdownFlag", powerdownFlag, 1'b0);
            check("watchdogClear", 32'(clrCnt - c0), 1);
            @(posedge clk);
            fire <= 11'h001 << i;
            @(posedge clk);
            fire <= '0;
            repeat (8) @(posedge clk);
            #1;
            check("coreStall", coreStall, 1'b1);
            @(posedge clk);
            enables <= 11'h001 << i;
            waitSig(coreStall, 1'b0, 40);
            repeat (3) @(posedge clk);
            #1;
            check("oscDriverOn", oscDriverOn, 1'b1);
            check("vectorJump", 32'(vecCnt - v0), 32'(globalIrqEnable));
            @(posedge clk);
            enables <= '0;
            clearFlags <= 1'b1;
        end
        @(posedge clk);
        {clearFlags, watchdogEnable} <= 2'b00;
        doSleep(11'h000);
        @(posedge clk);
        watchdogTimeout <= 1'b1;
        @(posedge clk);
        watchdogTimeout <= 1'b0;
        repeat (8) @(posedge clk);
        #1;
        check("coreStall", coreStall, 1'b1);
        @(posedge clk);
        {watchdogEnable, watchdogTimeout} <= 2'b11;
        @(posedge clk);
        watchdogTimeout <= 1'b0;
        waitSig(coreStall, 1'b0, 40);
        check("timeoutFlag", timeoutFlag, 1'b0);
        ahb(1'b0, 8'h00, 32'h0000_0000);
        check("statusBits", rd[4:3], 2'b00);
        @(posedge clk);
        enables <= 11'h002;
        doSleep(11'h002);
        waitSig(coreStall, 1'b0, 40);
        check("powerdownFlag", powerdownFlag, 1'b0);
        check("timeoutFlag", timeoutFlag, 1'b1);
        check("watchdogClear", 32'(clrCnt - c0), 1);
        @(posedge clk);
        powerOnReset <= 1'b1;
        @(posedge clk);
        powerOnReset <= 1'b0;
        repeat (4) @(posedge clk);
        #1;
        check("timeoutFlag", timeoutFlag, 1'b1);
        doSleep(11'h000);
        check("powerdownFlag", powerdownFlag, 1'b1);
        check("coreStall", coreStall, 1'b0);
        check("watchdogClear", 32'(clrCnt - c0), 0);
        ahb(1'b1, 8'h08, 32'h0000_0008);
        repeat (3) @(posedge clk);
        #1;
        check("irq", irq, 1'b1);
        ahb(1'b0, 8'h04, 32'h0000_0000);
        check("noOpEvent", rd[3], 1'b1);
        repeat (3) @(posedge clk);
        #1;
        check("irq", irq, 1'b0);
        ahb(1'b0, 8'h10, 32'h0000_0000);
        ahb(1'b1, 8'h0C, 32'h0000_0001);
        @(posedge clk);
        clearFlags <= 1'b1;
        enables <= 11'h001;
        @(posedge clk);
        clearFlags <= 1'b0;
        doSleep(11'h000);
        c0 = tickCnt;
        @(posedge clk);
        fire <= 11'h001;
        @(posedge clk);
        fire <= '0;
        waitSig(coreStall, 1'b0, 3000);
        check("startupTicks", 32'(tickCnt - c0 >= 1024 && tickCnt - c0 <= 1030), 1);
        @(posedge clk);
        {clearFlags, enables} <= {1'b1, 11'h000};
        doSleep(11'h000);
        v0 = vecCnt;
        @(posedge clk);
        masterClearPin <= 1'b0;
        waitSig(deviceReset, 1'b1, 10);
        check("vectorJump", 32'(vecCnt - v0), 0);
        @(posedge clk);
        masterClearPin <= 1'b1;
        repeat (10) @(posedge clk);
        results();
    end
endmodule : sleep_wakeup_controller_test
`default_nettype wire
